// File: src/fn_handler.sv
// request decoder and response generator of the serial slave
//
// What this block does
// - code 1 reads coils, up to 1970
// - code 2 reads discrete inputs, up to 1970
// - code 3 reads holding words, up to 125
// - code 4 reads input words, up to 125
// - code 5 forces one coil and output
// - code 15 forces up to 1970 coils
// - codes 6 and 16 always rejected, 16 to 125
// - holding registers never change on writes
// - code 7 returns eight exception coils
// - diag subfunction 0 echoes data field
// - diag subfunction 2 returns holding 129
// - broadcast only for codes 5,6,15,16
// - unprocessable query gets exception response
// - unsupported code gives exception 01
// - unmapped register gives exception 02
// - partial object read, codes 3 and 4, gives exception 02
// - write to read-only gives exception 03
// - not ready gives exception 06
// - other diag subfunction gives exception 08
// - pickup annunciation follows pickup condition
// - trip annunciation held minimum time
// - answer only own address 1..247
// - separate broadcast enables, coils, registers
`timescale 1ns/1ps
module fn_handler
	import fn_pkg::*;
#(
	parameter int TRIP_HOLD = TRIP_HOLD_CYC
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// configuration
	input  wire logic [7:0]        own_addr,
	input  wire logic              bcast_coil_en,
	input  wire logic              bcast_hold_en,
	input  wire logic              map_ready,
	// request from the frame layer
	input  wire logic              req_valid,
	input  req_t                   req,
	// register map lookup, combinational
	output map_t                   map_query_dummy,
	input  map_t                   map_info,
	input  wire logic [15:0]       diag_word,
	input  wire logic [7:0]        exc_coils,
	// response to the frame layer
	output logic                   rsp_valid,
	output rsp_t                   rsp,
	// coil force strobe
	output logic                   coil_wr,
	output logic [15:0]            coil_addr,
	output logic [15:0]            coil_qty,
	output logic [15:0]            coil_data,
	// protection annunciations
	input  wire logic [PROT_N-1:0] pickup_in,
	input  wire logic [PROT_N-1:0] trip_in,
	output logic [PROT_N-1:0]      pickup_ann,
	output logic [PROT_N-1:0]      trip_ann
);
	typedef struct packed {
		logic              rsp_valid;
		rsp_t              rsp;
		logic              coil_wr;
		logic [15:0]       coil_addr;
		logic [15:0]       coil_qty;
		logic [15:0]       coil_data;
		logic [PROT_N-1:0] pick_s1;
		logic [PROT_N-1:0] pick_s2;
		logic [PROT_N-1:0] trip_s1;
		logic [PROT_N-1:0] trip_s2;
		logic [PROT_N-1:0] pickup_ann;
		logic [PROT_N-1:0] trip_ann;
		logic [PROT_N-1:0][31:0] trip_cnt;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic qty_ok(input logic [15:0] q, input logic [15:0] lim);
		qty_ok = (q != 16'h0) && (q <= lim);
	endfunction

	logic       is_bcast;
	logic       is_own;
	logic       fc_known;
	logic       bcast_ok;
	logic [7:0] exc;
	logic       do_coil;

	assign map_query_dummy = '0;
	assign is_bcast = (req.slave == BCAST_ADDR);
	assign is_own   = (req.slave == own_addr) && (own_addr >= ADDR_MIN)
		&& (own_addr <= ADDR_MAX);

	always_comb begin
		unique case (req.func)
			FC_READ_COILS, FC_READ_DISCR, FC_READ_HOLD, FC_READ_INPUT,
			FC_WRITE_COIL, FC_WRITE_REG, FC_EXC_STATUS, FC_DIAG,
			FC_WRITE_COILS, FC_WRITE_REGS: fc_known = 1'b1;
			default: fc_known = 1'b0;
		endcase
	end

	// broadcast allowed only for writes, with separate enables
	always_comb begin
		unique case (req.func)
			FC_WRITE_COIL, FC_WRITE_COILS: bcast_ok = bcast_coil_en;
			FC_WRITE_REG, FC_WRITE_REGS:   bcast_ok = bcast_hold_en;
			default:                       bcast_ok = 1'b0;
		endcase
	end

	// exception priority: function, busy, quantity, address, value
	always_comb begin
		exc = EX_NONE;
		if (!fc_known) begin
			exc = EX_FUNC;
		end else if (!map_ready) begin
			exc = EX_BUSY;
		end else begin
			unique case (req.func)
				FC_READ_COILS, FC_READ_DISCR: begin
					if (!qty_ok(req.qty, MAX_BITS)) exc = EX_VALUE;
					else if (!map_info.mapped) exc = EX_ADDR;
				end
				FC_READ_HOLD, FC_READ_INPUT: begin
					if (!qty_ok(req.qty, MAX_WORDS)) exc = EX_VALUE;
					else if (!map_info.mapped) exc = EX_ADDR;
					else if (map_info.partial) exc = EX_ADDR;
				end
				FC_WRITE_COIL: begin
					if (!map_info.mapped) exc = EX_ADDR;
					else if (!map_info.writable) exc = EX_VALUE;
				end
				FC_WRITE_COILS: begin
					if (!qty_ok(req.qty, MAX_BITS)) exc = EX_VALUE;
					else if (!map_info.mapped) exc = EX_ADDR;
					else if (!map_info.writable) exc = EX_VALUE;
				end
				FC_WRITE_REG, FC_WRITE_REGS: begin
					if (req.func == FC_WRITE_REGS && !qty_ok(req.qty, MAX_WORDS))
						exc = EX_VALUE;
					else if (!map_info.mapped) exc = EX_ADDR;
					else exc = EX_VALUE;
				end
				FC_DIAG: begin
					if (req.addr != DIAG_LOOPBACK && req.addr != DIAG_REGISTER)
						exc = EX_NAK;
				end
				default: exc = EX_NONE;
			endcase
		end
	end

	assign do_coil = req_valid && (is_own || (is_bcast && bcast_ok)) && (exc == EX_NONE)
		&& (req.func == FC_WRITE_COIL || req.func == FC_WRITE_COILS);

	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		s_d.coil_wr = 1'b0;
		if (do_coil) begin
			s_d.coil_wr   = 1'b1;
			s_d.coil_addr = req.addr;
			s_d.coil_qty  = (req.func == FC_WRITE_COIL) ? 16'h1 : req.qty;
			s_d.coil_data = req.data;
		end
		// broadcasts are processed silently
		if (req_valid && is_own) begin
			s_d.rsp_valid  = 1'b1;
			s_d.rsp.normal = (exc == EX_NONE);
			s_d.rsp.func   = req.func;
			s_d.rsp.exc    = exc;
			s_d.rsp.addr   = req.addr;
			s_d.rsp.qty    = req.qty;
			s_d.rsp.data   = req.data;
			if (req.func == FC_EXC_STATUS) begin
				s_d.rsp.addr = EXC_COIL_BASE;
				s_d.rsp.qty  = 16'd8;
				s_d.rsp.data = {8'h00, exc_coils};
			end
			if (req.func == FC_DIAG && req.addr == DIAG_REGISTER) begin
				s_d.rsp.data = diag_word;
			end
			if (req.func == FC_DIAG && req.addr == DIAG_LOOPBACK) begin
				s_d.rsp.data = req.data;
			end
		end
		// annunciations
		s_d.pick_s1 = pickup_in;
		s_d.pick_s2 = s_q.pick_s1;
		s_d.trip_s1 = trip_in;
		s_d.trip_s2 = s_q.trip_s1;
		s_d.pickup_ann = s_q.pick_s2;
		for (int i = 0; i < PROT_N; i++) begin
			if (s_q.trip_s2[i]) begin
				s_d.trip_cnt[i] = 32'(TRIP_HOLD);
				s_d.trip_ann[i] = 1'b1;
			end else if (s_q.trip_cnt[i] > 32'h1) begin
				s_d.trip_cnt[i] = s_q.trip_cnt[i] - 32'h1;
				s_d.trip_ann[i] = 1'b1;
			end else begin
				s_d.trip_cnt[i] = TRIP_CNT_RST;
				s_d.trip_ann[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp_valid  = s_q.rsp_valid;
	assign rsp        = s_q.rsp;
	assign coil_wr    = s_q.coil_wr;
	assign coil_addr  = s_q.coil_addr;
	assign coil_qty   = s_q.coil_qty;
	assign coil_data  = s_q.coil_data;
	assign pickup_ann = s_q.pickup_ann;
	assign trip_ann   = s_q.trip_ann;

	sequence s_trip_seen;
		$rose(trip_ann[0]);
	endsequence

	a_bcast_silent: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_bcast |=> !rsp_valid)
		else $error("response to broadcast");
	a_bad_func: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && !fc_known |=> rsp_valid && rsp.exc == EX_FUNC && !rsp.normal)
		else $error("unsupported function not rejected");
	a_busy_exc: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && fc_known && !map_ready |=> rsp.exc == EX_BUSY)
		else $error("busy exception missing");
	a_hold_ro: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && map_ready && req.func == FC_WRITE_REG |=> !rsp.normal)
		else $error("holding write accepted");
	a_diag_nak: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && map_ready && req.func == FC_DIAG && req.addr > 16'h2
		|=> rsp.exc == EX_NAK)
		else $error("bad subfunction not rejected");
	a_loop_echo: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && map_ready && req.func == FC_DIAG && req.addr == 16'h0
		|=> rsp.normal && rsp.data == $past(req.data))
		else $error("loopback data changed");
	a_read_limit: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && map_ready && req.func == FC_READ_HOLD && req.qty > 16'd125
		|=> rsp.exc == EX_VALUE)
		else $error("holding read over limit accepted");
	a_bcast_read: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_bcast && req.func == FC_READ_COILS |=> !coil_wr && !rsp_valid)
		else $error("broadcast read processed");
	a_coil_force: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_own && map_ready && req.func == FC_WRITE_COIL && map_info.mapped
		&& map_info.writable |=> coil_wr && coil_qty == 16'h1)
		else $error("single coil not forced");
	a_pick_follow: assert property (@(posedge clock) disable iff (rst)
		##3 pickup_ann == $past(pickup_in, 3))
		else $error("pickup annunciation does not follow");
	a_trip_hold: assert property (@(posedge clock) disable iff (rst)
		s_trip_seen |=> trip_ann[0] [*8])
		else $error("trip annunciation dropped early");
endmodule

// File: src/fn_pkg.sv
// constants and carrier types of the serial slave function handler
package fn_pkg;
	// function codes
	localparam logic [7:0] FC_READ_COILS   = 8'h01;
	localparam logic [7:0] FC_READ_DISCR   = 8'h02;
	localparam logic [7:0] FC_READ_HOLD    = 8'h03;
	localparam logic [7:0] FC_READ_INPUT   = 8'h04;
	localparam logic [7:0] FC_WRITE_COIL   = 8'h05;
	localparam logic [7:0] FC_WRITE_REG    = 8'h06;
	localparam logic [7:0] FC_EXC_STATUS   = 8'h07;
	localparam logic [7:0] FC_DIAG         = 8'h08;
	localparam logic [7:0] FC_WRITE_COILS  = 8'h0f;
	localparam logic [7:0] FC_WRITE_REGS   = 8'h10;
	// limits
	localparam logic [15:0] MAX_BITS       = 16'd1970;
	localparam logic [15:0] MAX_WORDS      = 16'd125;
	// diagnostics
	localparam logic [15:0] DIAG_LOOPBACK  = 16'h0000;
	localparam logic [15:0] DIAG_REGISTER  = 16'h0002;
	localparam logic [15:0] DIAG_HOLD_ADDR = 16'd128;
	// exception status coils, zero based addresses 256..263
	localparam logic [15:0] EXC_COIL_BASE  = 16'd256;
	// slave address
	localparam logic [7:0] BCAST_ADDR      = 8'h00;
	localparam logic [7:0] ADDR_MIN        = 8'h01;
	localparam logic [7:0] ADDR_MAX        = 8'hf7;
	// exception codes
	localparam logic [7:0] EX_NONE         = 8'h00;
	localparam logic [7:0] EX_FUNC         = 8'h01;
	localparam logic [7:0] EX_ADDR         = 8'h02;
	localparam logic [7:0] EX_VALUE        = 8'h03;
	localparam logic [7:0] EX_BUSY         = 8'h06;
	localparam logic [7:0] EX_NAK          = 8'h08;
	// trip hold
	localparam int  CLK_MHZ                = 100;
	localparam int  MIN_TRIP_HOLD_MS       = 150;
	localparam int  TRIP_HOLD_CYC          = MIN_TRIP_HOLD_MS * CLK_MHZ * 1000;
	localparam int  PROT_N                 = 8;
	localparam logic [31:0] TRIP_CNT_RST   = 32'h0;

	// decoded request
	typedef struct packed {
		logic [7:0]  slave;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] qty;
		logic [15:0] data;
	} req_t;

	// response descriptor
	typedef struct packed {
		logic        normal;
		logic [7:0]  func;
		logic [7:0]  exc;
		logic [15:0] addr;
		logic [15:0] qty;
		logic [15:0] data;
	} rsp_t;

	// map lookup answer from the register map
	typedef struct packed {
		logic mapped;
		logic partial;
		logic writable;
	} map_t;
endpackage

// File: verif/master_model.sv
// request source standing in for the serial bus master
`timescale 1ns/1ps
module master_model
	import fn_pkg::*;
(
	// clock
	input  wire logic clock,
	// request to the handler
	output logic      req_valid,
	output req_t      req
);
	initial begin
		req_valid = 1'b0;
		req       = '0;
	end

	// one request per call; back-to-back calls give one request per cycle
	task automatic send(input req_t r);
		req_valid <= 1'b1;
		req       <= r;
		@(posedge clock);
	endtask

	// released fields show the inverse so stale values cannot pass
	task automatic idle();
		req_valid <= 1'b0;
		req       <= ~req;
		@(posedge clock);
	endtask
endmodule

// File: verif/modbus_slave_function_handler_tb.sv
// self-checking bench of the function handler
`timescale 1ns/1ps
module modbus_slave_function_handler_tb;
	import fn_pkg::*;
	typedef struct {rsp_t r; bit dchk;} exp_t;
	logic clock = 1'b0, rst = 1'b1, req_valid, bc_en = 1'b1, bh_en = 1'b1, ready = 1'b0;
	logic [7:0] own = 8'h11, excc = 8'h00, pk = 8'h00, tr = 8'h00;
	logic [15:0] dw = 16'h0000;
	map_t mi = '0;
	req_t req;
	logic rsp_valid, coil_wr;
	logic [15:0] ca, cq, cd;
	rsp_t rsp;
	logic [7:0] pka, tra;
	int n_fail = 0, samples_checked = 0, wr_exp = 0, wr_seen = 0;
	logic [31:0] seed = 32'd17744;
	exp_t q[$];
	logic [47:0] coil_exp[$];
	always #5 clock = ~clock;
	master_model i_master (.clock(clock), .req_valid(req_valid), .req(req));
	fn_handler #(.TRIP_HOLD(20)) i_dut (.clock(clock), .rst(rst), .own_addr(own),
		.bcast_coil_en(bc_en), .bcast_hold_en(bh_en), .map_ready(ready),
		.req_valid(req_valid), .req(req), .map_query_dummy(), .map_info(mi),
		.diag_word(dw), .exc_coils(excc), .rsp_valid(rsp_valid), .rsp(rsp),
		.coil_wr(coil_wr), .coil_addr(ca), .coil_qty(cq), .coil_data(cd),
		.pickup_in(pk), .trip_in(tr), .pickup_ann(pka), .trip_ann(tra));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (e !== s) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, s);
		end
	endtask

	// exception code a request must earn
	function automatic logic [7:0] exc_of(req_t r, map_t m, logic rdy);
		logic [15:0] lim;
		lim = (r.func inside {FC_READ_COILS, FC_READ_DISCR, FC_WRITE_COILS}) ? MAX_BITS : MAX_WORDS;
		if (!(r.func inside {[8'h01:8'h08], 8'h0f, 8'h10})) return EX_FUNC;
		if (!rdy) return EX_BUSY;
		if (r.func == FC_DIAG)
			return (r.addr inside {DIAG_LOOPBACK, DIAG_REGISTER}) ? EX_NONE : EX_NAK;
		if (r.func == FC_EXC_STATUS) return EX_NONE;
		if (r.qty == 16'h0 || r.qty > lim) return EX_VALUE;
		if (!m.mapped || m.partial) return EX_ADDR;
		if (r.func inside {FC_WRITE_REG, FC_WRITE_REGS}) return EX_VALUE;
		if (r.func inside {FC_WRITE_COIL, FC_WRITE_COILS} && !m.writable)
			return EX_VALUE;
		return EX_NONE;
	endfunction

	// response monitor, on the falling edge so registered outputs have settled
	always @(negedge clock) begin
		exp_t e;
		logic [47:0] c;
		if (coil_wr === 1'b1) begin
			wr_seen++;
			if (coil_exp.size() == 0) begin
				cmp("unexpected coil write", 16'h0, 16'h1);
			end else begin
				c = coil_exp.pop_front();
				cmp("coil address", c[47:32], ca);
				cmp("coil quantity", c[31:16], cq);
				cmp("coil data", c[15:0], cd);
			end
		end
		if (rsp_valid === 1'b1) begin
			if (q.size() == 0) begin
				cmp("unexpected response", 16'h0, 16'h1);
			end else begin
				e = q.pop_front();
				cmp("normal", 16'(e.r.normal), 16'(rsp.normal));
				cmp("exception", 16'(e.r.exc), 16'(rsp.exc));
				if (e.r.normal) cmp("function", 16'(e.r.func), 16'(rsp.func));
				cmp("address", e.r.addr, rsp.addr);
				cmp("quantity", e.r.qty, rsp.qty);
				if (e.dchk) cmp("data", e.r.data, rsp.data);
			end
		end
	end

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		n_fail++;
		wrap_up();
	end

	initial begin
		logic [7:0] fcs [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
			8'h0f, 8'h10, 8'h09, 8'h2b};
		logic [15:0] qs [6] = '{16'd0, 16'd1, 16'd125, 16'd126, 16'd1970, 16'd1971};
		logic [15:0] subs [4] = '{16'h0, 16'h2, 16'h1, 16'h4};
		req_t r;
		map_t m;
		exp_t e;
		logic [7:0] x;
		logic rdy, bc;
		logic [7:0] xc;
		logic [15:0] dv;
		logic bce, bhe;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 600; i++) begin
			r.func = fcs[rnd() % 12];
			r.slave = (rnd() % 4 == 0) ? BCAST_ADDR : ((rnd() % 5 == 0) ? 8'h12 : own);
			r.addr = (r.func == FC_DIAG) ? subs[rnd() % 4] : 16'(rnd());
			r.qty = (r.func inside {FC_WRITE_COIL, FC_WRITE_REG}) ? 16'h1 : qs[rnd() % 6];
			r.data = 16'(rnd());
			m = 3'(rnd());
			if (!(r.func inside {FC_READ_HOLD, FC_READ_INPUT})) m.partial = 1'b0;
			rdy = (rnd() % 8 != 0);
			// side inputs drawn now so the expectation sees what the design samples
			xc = 8'(rnd());
			dv = 16'(rnd());
			bce = 1'(rnd());
			bhe = 1'(rnd());
			x = exc_of(r, m, rdy);
			bc = (r.func inside {FC_WRITE_COIL, FC_WRITE_COILS}) ? bce : 1'b0;
			if (r.func == FC_WRITE_COIL || r.func == FC_WRITE_COILS)
				if (x == EX_NONE && (r.slave == own || (r.slave == BCAST_ADDR && bc))) begin
					wr_exp++;
					coil_exp.push_back({r.addr, (r.func == FC_WRITE_COIL) ? 16'h1 : r.qty, r.data});
				end
			if (r.slave == own) begin
				e.r = '0;
				e.r.normal = (x == EX_NONE);
				e.r.func = r.func;
				e.r.exc = x;
				e.r.addr = (r.func == FC_EXC_STATUS) ? EXC_COIL_BASE : r.addr;
				e.r.qty = (r.func == FC_EXC_STATUS) ? 16'd8 : r.qty;
				e.dchk = e.r.normal && (r.func inside {FC_EXC_STATUS, FC_DIAG});
				e.r.data = (r.func == FC_EXC_STATUS) ? {8'h00, xc} :
					((r.addr == DIAG_REGISTER) ? dv : r.data);
				q.push_back(e);
			end
			ready <= rdy;
			mi <= m;
			excc <= xc;
			dw <= dv;
			bc_en <= bce;
			bh_en <= bhe;
			i_master.send(r);
		end
		i_master.idle();
		repeat (4) @(posedge clock);
		cmp("pending responses", 16'h0, 16'(q.size()));
		cmp("coil writes", 16'(wr_exp), 16'(wr_seen));
		cmp("pending coil writes", 16'h0, 16'(coil_exp.size()));
		pk <= 8'ha5;
		repeat (6) @(posedge clock);
		cmp("pickup on", 16'h00a5, 16'(pka));
		pk <= 8'h00;
		repeat (6) @(posedge clock);
		cmp("pickup off", 16'h0, 16'(pka));
		tr <= 8'h01;
		repeat (2) @(posedge clock);
		tr <= 8'h00;
		repeat (12) @(posedge clock);
		cmp("trip held", 16'h1, 16'(tra));
		repeat (30) @(posedge clock);
		cmp("trip off", 16'h0, 16'(tra));
		wrap_up();
	end
endmodule
